// ===== src/eeprom_defs.vh
// constants for the two-wire serial eeprom slave
// Contract
// - extra write bytes sit in the page buffer; array updated only after stop
// - each written data byte bumps only the low five pointer bits
// - more than a page of bytes wraps the buffer, newest bytes replace oldest
// - stop after a write command starts the timed internal write cycle
// - protected write still acknowledged, then dropped, device ready at once
// - writes past page end wrap to the same page start, never the next
// - protect input high blocks writes to every address, low permits them
// - protect input sampled once at stop of each write command
// - no control byte acknowledge while the write cycle runs
// - direction bit one in the control byte selects a read
// - address counter holds last address plus one for current reads
// - current read sends one byte; master nacks, stops; device releases data
// - random read: address loads pointer, repeated start abandons the write
// - after a random read the counter points past the byte read
// - each master acknowledge fetches the next byte; nack plus stop ends
// - acknowledge after the top address wraps the pointer to zero
// - control byte carries type code and three chip selects that must match
// - two address bytes, high first, only twelve bits kept
`ifndef EEPROM_DEFS_VH
`define EEPROM_DEFS_VH
`define CLK_PERIOD_NS   20
`define WRITE_TIME_NS   5000000
`define TIMER_W         24
`define ADDR_W          12
`define PAGE_AW         5
`define DATA_W          8
`define PAGE_BYTES      32
`define PAGE_LAST       5'h1F
`define FIFO_DEPTH      4
`define FIFO_AW         2
`define BITS_PER_BYTE   4'h8
`define ARRAY_GAP       3'h7
`define TYPE_CODE_DEF   4'h5
`define ADDR_HI_LSB     8
`define ADDR_HI_BITS    4
`endif

// ===== src/eeprom_store.v
// write fifo and byte memory used by the eeprom slave
`timescale 1ns/10ps
module sync_fifo #(
   parameter WIDTH = 20,
   parameter DEPTH = 4,
   parameter AW    = 2
) (
   input  wire             i_ref_clk,
   input  wire             i_reset_n,
   input  wire             i_clk_en,
   input  wire             i_in_valid,
   output wire             o_in_ready,
   input  wire [WIDTH-1:0] i_in_data,
   output wire             o_out_valid,
   input  wire             i_out_ready,
   output wire [WIDTH-1:0] o_out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_q;
   reg [AW-1:0]    rd_q;
   reg [AW:0]      cnt_q;
   wire            push;
   wire            pop;

   assign o_in_ready  = (cnt_q != DEPTH[AW:0]);
   assign o_out_valid = (cnt_q != {(AW+1){1'b0}});
   assign push = i_clk_en && i_in_valid && o_in_ready;
   assign pop  = i_clk_en && o_out_valid && i_out_ready;

   // continuous read, so a word pushed into an empty fifo shows at once
   assign o_out_data = mem[rd_q];

   always @(posedge i_ref_clk)
   begin
      if (push)
         mem[wr_q] <= i_in_data;
   end

   always @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         wr_q  <= {AW{1'b0}};
         rd_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
            wr_q <= wr_q + 1'b1;
         if (pop)
            rd_q <= rd_q + 1'b1;
         if (push && !pop)
            cnt_q <= cnt_q + 1'b1;
         else if (pop && !push)
            cnt_q <= cnt_q - 1'b1;
      end
   end
endmodule // sync_fifo

module byte_ram #(
   parameter AW = 12,
   parameter DW = 8
) (
   input  wire          i_ref_clk,
   input  wire          i_clk_en,
   input  wire          i_we,
   input  wire [AW-1:0] i_waddr,
   input  wire [DW-1:0] i_wdata,
   input  wire [AW-1:0] i_raddr,
   output reg  [DW-1:0] o_rdata
);
   reg [DW-1:0] mem [0:(1<<AW)-1];

   // no reset on the array: contents are non-volatile in spirit
   always @(posedge i_ref_clk)
   begin
      if (i_clk_en)
      begin
         if (i_we)
            mem[i_waddr] <= i_wdata;
         o_rdata <= mem[i_raddr];
      end
   end
endmodule // byte_ram

// ===== src/serial_eeprom_write_read_control.v
// two-wire serial eeprom slave: page writes, protect, polling, reads
`timescale 1ns/10ps
`include "eeprom_defs.vh"
module serial_eeprom_write_read_control #(
   parameter [`TIMER_W-1:0] WRITE_CYCLE_CYCLES = `WRITE_TIME_NS / `CLK_PERIOD_NS,
   // arbitrary device type value, not any maker's code
   parameter [3:0]          DEVICE_TYPE        = `TYPE_CODE_DEF
) (
   input  wire       i_ref_clk,
   input  wire       i_reset_n,
   input  wire       i_clk_en,
   input  wire       i_scl,
   input  wire       i_sda,
   output wire       o_sda_out,
   output wire       o_sda_oe,
   input  wire       i_write_protect,
   input  wire [2:0] i_chip_select_inputs,
   output wire       o_write_busy
);
   localparam [7:0] ST_IDLE = 8'h01;
   localparam [7:0] ST_CTRL = 8'h02;
   localparam [7:0] ST_AHI  = 8'h04;
   localparam [7:0] ST_ALO  = 8'h08;
   localparam [7:0] ST_WDAT = 8'h10;
   localparam [7:0] ST_RDAT = 8'h20;
   localparam [7:0] ST_RACK = 8'h40;
   localparam [7:0] ST_ACK  = 8'h80;
   localparam       FW      = `ADDR_W + `DATA_W;

   // pin synchronisers; stage one feeds only stage two
   reg  [5:0]              sync1_q;
   reg  [5:0]              sync2_q;
   reg                     scl_d_q;
   reg                     sda_d_q;
   wire                    scl_s;
   wire                    sda_s;
   wire                    wp_s;
   wire [2:0]              cs_s;
   wire                    scl_rise;
   wire                    scl_fall;
   wire                    start_ev;
   wire                    stop_ev;

   reg  [7:0]              state_q;
   reg  [7:0]              nxt_q;
   reg  [3:0]              bitcnt_q;
   reg  [`DATA_W-1:0]      shift_q;
   reg  [`DATA_W-1:0]      tx_q;
   reg  [`ADDR_W-1:0]      ptr_q;
   reg  [`PAGE_BYTES-1:0]  valid_q;
   reg                     wr_data_q;
   reg                     mack_q;
   reg                     sda_oe_q;

   reg                     busy_q;
   reg                     scanning_q;
   reg  [`PAGE_AW-1:0]     scan_idx_q;
   reg                     s1_v_q;
   reg  [`PAGE_AW-1:0]     s1_idx_q;
   reg  [`ADDR_W-`PAGE_AW-1:0] page_q;
   reg  [`TIMER_W-1:0]     timer_q;
   reg  [2:0]              gap_q;

   wire                    byte_done;
   wire                    pb_we;
   wire [`PAGE_AW-1:0]     pb_raddr;
   wire [`DATA_W-1:0]      pb_q;
   wire [`DATA_W-1:0]      arr_q;
   wire                    commit_go;
   wire                    push_want;
   wire                    advance;
   wire                    fifo_in_ready;
   wire                    fifo_out_valid;
   wire                    fifo_out_ready;
   wire [FW-1:0]           fifo_out_data;
   wire                    timer_done;

   // control byte decode: type code, chip selects, direction in bit 0
   function ctrl_match;
      input [`DATA_W-1:0] b;
      input [2:0]         cs;
      begin
         ctrl_match = (b[7:4] == DEVICE_TYPE) && (b[3:1] == cs);
      end
   endfunction

   // in-page increment keeps the page number untouched
   function [`ADDR_W-1:0] page_inc;
      input [`ADDR_W-1:0] a;
      begin
         page_inc = {a[`ADDR_W-1:`PAGE_AW], a[`PAGE_AW-1:0] + 1'b1};
      end
   endfunction

   assign scl_s    = sync2_q[0];
   assign sda_s    = sync2_q[1];
   assign wp_s     = sync2_q[2];
   assign cs_s     = sync2_q[5:3];
   assign scl_rise = scl_s && !scl_d_q;
   assign scl_fall = !scl_s && scl_d_q;
   assign start_ev = scl_s && scl_d_q && sda_d_q && !sda_s;
   assign stop_ev  = scl_s && scl_d_q && !sda_d_q && sda_s;

   assign o_sda_out    = 1'b0;
   assign o_sda_oe     = sda_oe_q;
   assign o_write_busy = busy_q;

   assign byte_done = scl_fall && (bitcnt_q == `BITS_PER_BYTE) && !start_ev && !stop_ev;
   // buffer only, array untouched until stop
   assign pb_we = i_clk_en && (state_q == ST_WDAT) && byte_done;
   // protect sampled at stop, write cycle skipped when high
   assign commit_go = i_clk_en && stop_ev && wr_data_q && !busy_q && !wp_s;

   always @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         sync1_q <= 6'h00;
         sync2_q <= 6'h00;
         scl_d_q <= 1'b0;
         sda_d_q <= 1'b0;
      end
      else if (i_clk_en)
      begin
         sync1_q <= {i_chip_select_inputs, i_write_protect, i_sda, i_scl};
         sync2_q <= sync1_q;
         scl_d_q <= scl_s;
         sda_d_q <= sda_s;
      end
   end

   // command engine
   always @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         state_q   <= ST_IDLE;
         nxt_q     <= ST_IDLE;
         bitcnt_q  <= 4'h0;
         shift_q   <= 8'h00;
         tx_q      <= 8'h00;
         ptr_q     <= 12'h000;
         valid_q   <= 32'h00000000;
         wr_data_q <= 1'b0;
         mack_q    <= 1'b0;
         sda_oe_q  <= 1'b0;
      end
      else if (i_clk_en)
      begin
         if (start_ev)
         begin
            // repeated start abandons a write command not yet stopped; a running write cycle goes on
            state_q   <= ST_CTRL;
            bitcnt_q  <= 4'h0;
            sda_oe_q  <= 1'b0;
            wr_data_q <= 1'b0;
         end
         else if (stop_ev)
         begin
            // release the line; reads end here
            state_q   <= ST_IDLE;
            sda_oe_q  <= 1'b0;
            wr_data_q <= 1'b0;
         end
         else
         begin
            case (state_q)
               ST_CTRL, ST_AHI, ST_ALO, ST_WDAT:
               begin
                  if (scl_rise)
                  begin
                     shift_q  <= {shift_q[6:0], sda_s};
                     bitcnt_q <= bitcnt_q + 1'b1;
                  end
                  else if (byte_done)
                  begin
                     state_q <= ST_ACK;
                     case (state_q)
                        ST_CTRL:
                        begin
                           // silent while busy so polling sees no ack
                           if (ctrl_match(shift_q, cs_s) && !busy_q)
                           begin
                              sda_oe_q <= 1'b1;
                              nxt_q    <= shift_q[0] ? ST_RDAT : ST_AHI;
                              if (!shift_q[0])
                                 valid_q <= 32'h00000000;
                           end
                           else
                              state_q <= ST_IDLE;
                        end
                        ST_AHI:
                        begin
                           // top four address bits dropped
                           ptr_q[`ADDR_W-1:`ADDR_HI_LSB] <= shift_q[`ADDR_HI_BITS-1:0];
                           sda_oe_q <= 1'b1;
                           nxt_q    <= ST_ALO;
                        end
                        ST_ALO:
                        begin
                           ptr_q[`ADDR_HI_LSB-1:0] <= shift_q;
                           sda_oe_q <= 1'b1;
                           nxt_q    <= ST_WDAT;
                        end
                        default:
                        begin
                           // ack even when protected
                           valid_q[ptr_q[`PAGE_AW-1:0]] <= 1'b1;
                           ptr_q     <= page_inc(ptr_q);
                           wr_data_q <= 1'b1;
                           sda_oe_q  <= 1'b1;
                           nxt_q     <= ST_WDAT;
                        end
                     endcase
                  end
               end
               ST_ACK:
               begin
                  if (scl_fall)
                  begin
                     bitcnt_q <= 4'h0;
                     state_q  <= nxt_q;
                     if (nxt_q == ST_RDAT)
                     begin
                        // pointer ends one past the byte sent
                        tx_q     <= arr_q;
                        ptr_q    <= ptr_q + 1'b1;
                        sda_oe_q <= ~arr_q[7];
                     end
                     else
                        sda_oe_q <= 1'b0;
                  end
               end
               ST_RDAT:
               begin
                  if (scl_rise)
                     bitcnt_q <= bitcnt_q + 1'b1;
                  else if (scl_fall)
                  begin
                     if (bitcnt_q == `BITS_PER_BYTE)
                     begin
                        sda_oe_q <= 1'b0;
                        state_q  <= ST_RACK;
                     end
                     else
                     begin
                        tx_q     <= {tx_q[6:0], 1'b0};
                        sda_oe_q <= ~tx_q[6];
                     end
                  end
               end
               ST_RACK:
               begin
                  if (scl_rise)
                     mack_q <= ~sda_s;
                  else if (scl_fall)
                  begin
                     bitcnt_q <= 4'h0;
                     if (mack_q)
                     begin
                        // next byte; twelve-bit pointer wraps top to zero
                        tx_q     <= arr_q;
                        ptr_q    <= ptr_q + 1'b1;
                        sda_oe_q <= ~arr_q[7];
                        state_q  <= ST_RDAT;
                     end
                     else
                     begin
                        // nack: leave the line high for stop
                        sda_oe_q <= 1'b0;
                        state_q  <= ST_IDLE;
                     end
                  end
               end
               ST_IDLE:
                  sda_oe_q <= 1'b0;
               default:
               begin
                  state_q  <= ST_IDLE;
                  sda_oe_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // write cycle: drain buffered bytes through the fifo, paced into the array
   assign push_want = s1_v_q && valid_q[s1_idx_q];
   assign advance   = !(push_want && !fifo_in_ready);
   assign pb_raddr  = advance ? scan_idx_q : s1_idx_q;
   assign timer_done = (timer_q == WRITE_CYCLE_CYCLES - 1'b1);
   assign fifo_out_ready = (gap_q == 3'h0);

   always @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         busy_q     <= 1'b0;
         scanning_q <= 1'b0;
         scan_idx_q <= 5'h00;
         s1_v_q     <= 1'b0;
         s1_idx_q   <= 5'h00;
         page_q     <= 7'h00;
         timer_q    <= 24'h000000;
         gap_q      <= 3'h0;
      end
      else if (i_clk_en)
      begin
         if (commit_go)
         begin
            busy_q     <= 1'b1;
            scanning_q <= 1'b1;
            scan_idx_q <= 5'h00;
            s1_v_q     <= 1'b0;
            page_q     <= ptr_q[`ADDR_W-1:`PAGE_AW]; // same page only
            timer_q    <= 24'h000000;
         end
         else if (busy_q)
         begin
            if (advance)
            begin
               s1_v_q   <= scanning_q;
               s1_idx_q <= scan_idx_q;
               if (scanning_q)
               begin
                  scan_idx_q <= scan_idx_q + 1'b1;
                  if (scan_idx_q == `PAGE_LAST)
                     scanning_q <= 1'b0;
               end
            end
            if (!timer_done)
               timer_q <= timer_q + 1'b1;
            // busy lasts the full timer and until every byte landed
            else if (!scanning_q && !s1_v_q && !fifo_out_valid)
               busy_q <= 1'b0;
         end
         // pacing slows the array side, so the fifo genuinely backs up
         if (fifo_out_valid)
            gap_q <= (gap_q == 3'h0) ? `ARRAY_GAP : gap_q - 1'b1;
      end
   end

   byte_ram #(
      .AW (`PAGE_AW),
      .DW (`DATA_W)
   ) page_buf (
      .i_ref_clk (i_ref_clk),
      .i_clk_en  (i_clk_en),
      .i_we      (pb_we),
      .i_waddr   (ptr_q[`PAGE_AW-1:0]),
      .i_wdata   (shift_q),
      .i_raddr   (pb_raddr),
      .o_rdata   (pb_q)
   );

   sync_fifo #(
      .WIDTH (FW),
      .DEPTH (`FIFO_DEPTH),
      .AW    (`FIFO_AW)
   ) commit_fifo (
      .i_ref_clk   (i_ref_clk),
      .i_reset_n   (i_reset_n),
      .i_clk_en    (i_clk_en),
      .i_in_valid  (push_want),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   ({page_q, s1_idx_q, pb_q}),
      .o_out_valid (fifo_out_valid),
      .i_out_ready (fifo_out_ready),
      .o_out_data  (fifo_out_data)
   );

   byte_ram #(
      .AW (`ADDR_W),
      .DW (`DATA_W)
   ) array (
      .i_ref_clk (i_ref_clk),
      .i_clk_en  (i_clk_en),
      .i_we      (fifo_out_valid && fifo_out_ready),
      .i_waddr   (fifo_out_data[FW-1:`DATA_W]),
      .i_wdata   (fifo_out_data[`DATA_W-1:0]),
      .i_raddr   (ptr_q),
      .o_rdata   (arr_q)
   );
endmodule // serial_eeprom_write_read_control

// ===== testbench/serial_eeprom_sva.sv
// assertion checker for the serial eeprom slave ports
`timescale 1ns/10ps
module serial_eeprom_sva #(
   parameter [23:0] WRITE_CYCLE_CYCLES = 24'd200
) (
   input wire       i_ref_clk,
   input wire       i_reset_n,
   input wire       i_clk_en,
   input wire       i_scl,
   input wire       i_sda,
   input wire       o_sda_out,
   input wire       o_sda_oe,
   input wire       i_write_protect,
   input wire [2:0] i_chip_select_inputs,
   input wire       o_write_busy
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);
   logic [23:0] busy_len;
   logic [7:0]  since_stop;
   logic        sda_q;
   wire         stop_now = i_scl && i_sda && !sda_q;
   sequence stop_seq;
      stop_now;
   endsequence
   // protect held steady across the synchronisers before the stop
   sequence prot_stop_seq;
      stop_seq ##0 (i_write_protect && $past(i_write_protect, 4) && !o_write_busy);
   endsequence
   always @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         busy_len   <= 24'h000000;
         since_stop <= 8'hFF;
         sda_q      <= 1'b1;
      end
      else
      begin
         sda_q      <= i_sda;
         busy_len   <= o_write_busy ? busy_len + 24'h000001 : 24'h000000;
         since_stop <= stop_now ? 8'h00 : (since_stop == 8'hFF ? 8'hFF : since_stop + 8'h01);
      end
   end
   sda_drive_zero_a: assert property (o_sda_out == 1'b0)
      else $error("data drive value is not low");
   busy_after_stop_a: assert property ($rose(o_write_busy) |-> since_stop <= 8'h08)
      else $error("write cycle began without a stop");
   busy_min_time_a: assert property ($fell(o_write_busy) |-> busy_len >= WRITE_CYCLE_CYCLES)
      else $error("write cycle ended too early");
   // drain of a full page runs beside the timer and outlasts it by some tens of cycles
   busy_max_time_a: assert property (o_write_busy |-> busy_len < WRITE_CYCLE_CYCLES + 24'd600)
      else $error("write cycle lasts too long");
   busy_no_ack_a: assert property (o_write_busy && $past(o_write_busy, 8) |-> !o_sda_oe)
      else $error("acknowledge driven during write cycle");
   protect_no_cycle_a: assert property (prot_stop_seq |=> (!o_write_busy) [*8])
      else $error("write cycle began while protected");
   stop_release_a: assert property (stop_seq |-> ##4 (!o_sda_oe) [*6])
      else $error("data line held after stop");
   oe_stable_high_a: assert property ($rose(i_scl) |=> $stable(o_sda_oe) [*2])
      else $error("data drive changed while clock high");
endmodule // serial_eeprom_sva

bind serial_eeprom_write_read_control serial_eeprom_sva #(
   .WRITE_CYCLE_CYCLES(WRITE_CYCLE_CYCLES)
) i_serial_eeprom_sva (
   .i_ref_clk(i_ref_clk),
   .i_reset_n(i_reset_n),
   .i_clk_en(i_clk_en),
   .i_scl(i_scl),
   .i_sda(i_sda),
   .o_sda_out(o_sda_out),
   .o_sda_oe(o_sda_oe),
   .i_write_protect(i_write_protect),
   .i_chip_select_inputs(i_chip_select_inputs),
   .o_write_busy(o_write_busy)
);

// ===== testbench/two_wire_master.sv
// two-wire bus master model issuing eeprom commands
`timescale 1ns/10ps
module two_wire_master (
   input  wire i_ref_clk,
   input  wire i_sda,
   output reg  o_scl,
   output reg  o_sda_oe
);
   initial
   begin
      o_scl    = 1'b1;
      o_sda_oe = 1'b0;
   end
   task tick(input int n);
      repeat (n) @(posedge i_ref_clk);
   endtask
   // serves as repeated start too: line released before clock goes high
   task start();
      o_sda_oe <= 1'b0;
      tick(2);
      o_scl <= 1'b1;
      tick(4);
      o_sda_oe <= 1'b1;
      tick(4);
      o_scl <= 1'b0;
      tick(2);
   endtask
   // data moves mid low phase only, sampled mid high phase
   task bit_xfer(input logic b, output logic r);
      o_sda_oe <= ~b;
      tick(2);
      o_scl <= 1'b1;
      tick(2);
      r = i_sda;
      tick(2);
      o_scl <= 1'b0;
      tick(2);
   endtask
   task wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_xfer(d[i], r);
      bit_xfer(1'b1, r);
      ack = ~r;
   endtask
   task rbyte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_xfer(1'b1, r);
         d[i] = r;
      end
      bit_xfer(~ack, r);
   endtask
   task stop();
      o_sda_oe <= 1'b1;
      tick(2);
      o_scl <= 1'b1;
      tick(4);
      o_sda_oe <= 1'b0;
      tick(6);
   endtask
   // bounded so a device that never answers cannot hang the run
   task poll(input logic [7:0] ctrl, output int tries);
      logic ack;
      tries = 0;
      ack = 1'b0;
      while (!ack && tries < 40)
      begin
         start();
         wbyte(ctrl, ack);
         tries++;
      end
      stop();
   endtask
endmodule // two_wire_master

// ===== testbench/serial_eeprom_write_read_control_test.sv
// self-checking bench for the serial eeprom slave
`timescale 1ns/10ps
module serial_eeprom_write_read_control_test;
   localparam int         WCYC = 200;
   localparam logic [7:0] CW   = 8'h5A;
   localparam logic [7:0] CR   = 8'h5B;
   logic       ref_clk       = 1'b0;
   logic       reset_n       = 1'b0;
   logic       write_protect = 1'b0;
   logic [2:0] chip_sel      = 3'h5;
   logic       clk_en        = 1'b1;
   logic [7:0] got [0:3];
   int         error_cnt     = 0;
   int         checks_done   = 0;
   wire        scl;
   wire        master_oe;
   wire        sda_out;
   wire        sda_oe;
   wire        write_busy;
   wire        sda           = ~(sda_oe | master_oe);
   always #10 ref_clk = ~ref_clk;
   two_wire_master i_two_wire_master (
      .i_ref_clk(ref_clk),
      .i_sda(sda),
      .o_scl(scl),
      .o_sda_oe(master_oe)
   );
   // arbitrary type code, not any maker's value
   serial_eeprom_write_read_control #(
      .WRITE_CYCLE_CYCLES(WCYC),
      .DEVICE_TYPE(4'h5)
   ) i_serial_eeprom_write_read_control (
      .i_ref_clk(ref_clk),
      .i_reset_n(reset_n),
      .i_clk_en(clk_en),
      .i_scl(scl),
      .i_sda(sda),
      .o_sda_out(sda_out),
      .o_sda_oe(sda_oe),
      .i_write_protect(write_protect),
      .i_chip_select_inputs(chip_sel),
      .o_write_busy(write_busy)
   );
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task results();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // top nibble of the high address byte is junk on purpose
   task set_addr(input logic [11:0] a);
      logic ack;
      i_two_wire_master.start();
      i_two_wire_master.wbyte(CW, ack);
      chk(8'(ack), 8'h01);
      i_two_wire_master.wbyte({4'hF, a[11:8]}, ack);
      chk(8'(ack), 8'h01);
      i_two_wire_master.wbyte(a[7:0], ack);
      chk(8'(ack), 8'h01);
   endtask
   task wr(input logic [11:0] a, input logic [7:0] base, input int n);
      logic ack;
      set_addr(a);
      for (int i = 0; i < n; i++)
      begin
         i_two_wire_master.wbyte(base + 8'(i), ack);
         chk(8'(ack), 8'h01);
      end
      i_two_wire_master.stop();
   endtask
   task rd(input logic [11:0] a, input int n, input logic cur);
      logic ack;
      if (!cur)
         set_addr(a);
      i_two_wire_master.start();
      i_two_wire_master.wbyte(CR, ack);
      chk(8'(ack), 8'h01);
      for (int i = 0; i < n; i++)
         i_two_wire_master.rbyte(i < n - 1, got[i]);
      i_two_wire_master.stop();
   endtask
   task wait_done(input logic busy_exp);
      int tries;
      @(posedge ref_clk);
      chk(8'(write_busy), 8'(busy_exp));
      i_two_wire_master.poll(CW, tries);
      if (tries >= 40)
      begin
         error_cnt++;
         results();
      end
      else
         chk(8'(tries > 1), 8'(busy_exp));
   endtask
   task ctrl_only(input logic [7:0] c, input logic e);
      logic ack;
      i_two_wire_master.start();
      i_two_wire_master.wbyte(c, ack);
      chk(8'(ack), 8'(e));
      i_two_wire_master.stop();
   endtask
   task s_refuse();
      ctrl_only(8'h58, 1'b0);
      ctrl_only(8'hDA, 1'b0);
      chip_sel <= 3'h2;
      ctrl_only(8'h54, 1'b1);
      ctrl_only(CW, 1'b0);
      chip_sel <= 3'h5;
   endtask
   task s_write_read();
      wr(12'h020, 8'h10, 4);
      wait_done(1'b1);
      rd(12'h020, 3, 1'b0);
      for (int i = 0; i < 3; i++)
         chk(got[i], 8'h10 + 8'(i));
      rd(12'h000, 1, 1'b1);
      chk(got[0], 8'h13);
   endtask
   // crosses the page end on purpose to see the wrap
   task s_page_wrap();
      wr(12'h01E, 8'h40, 34);
      wait_done(1'b1);
      rd(12'h01E, 4, 1'b0);
      chk(got[0], 8'h60);
      chk(got[1], 8'h61);
      chk(got[2], 8'h10);
      chk(got[3], 8'h11);
      rd(12'h000, 2, 1'b0);
      chk(got[0], 8'h42);
      chk(got[1], 8'h43);
   endtask
   task s_roll();
      wr(12'hFFF, 8'hA5, 1);
      // enable low freezes the write timer, so busy must outlast it
      clk_en <= 1'b0;
      repeat (300) @(posedge ref_clk);
      chk(8'(write_busy), 8'h01);
      clk_en <= 1'b1;
      wait_done(1'b1);
      rd(12'hFFF, 2, 1'b0);
      chk(got[0], 8'hA5);
      chk(got[1], 8'h42);
   endtask
   task s_protect();
      write_protect <= 1'b1;
      wr(12'h020, 8'hC0, 2);
      wait_done(1'b0);
      rd(12'h020, 2, 1'b0);
      chk(got[0], 8'h10);
      chk(got[1], 8'h11);
      write_protect <= 1'b0;
      wr(12'h021, 8'hD0, 1);
      write_protect <= 1'b1;
      wait_done(1'b1);
      rd(12'h021, 1, 1'b0);
      chk(got[0], 8'hD0);
      write_protect <= 1'b0;
   endtask
   initial
   begin
      repeat (16) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      s_refuse();
      s_write_read();
      s_page_wrap();
      s_roll();
      s_protect();
      results();
   end
endmodule // serial_eeprom_write_read_control_test
